// file: evr_pkg.sv
/*
 * constants of the event router register bank: offsets, field positions,
 * reset values, bus answer codes.
 * assumes a 32-bit AXI4-Lite register port and eight event channels.
 */
package evr_pkg;

	// ****************************************************************
	// geometry
	// ****************************************************************
	localparam int NUM_CH = 8;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;

	// ****************************************************************
	// register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFS_UNIT_CONTROL = 8'h00;
	localparam logic [7:0] OFS_CHANNEL_STATUS = 8'h0c;
	localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR = 8'h10;
	localparam logic [7:0] OFS_IRQ_ENABLE_SET = 8'h14;
	localparam logic [7:0] OFS_IRQ_FLAGS = 8'h18;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int SOFT_RESET_BIT = 0;
	localparam int USERS_READY_LSB = 0;
	localparam int CHANNEL_BUSY_LSB = 16;
	localparam int OVERRUN_LSB = 0;
	localparam int EVENT_DETECTED_LSB = 16;
	localparam int LOW_LANE = 0;
	localparam int HIGH_LANE = 2;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [7:0] RST_UNIT_CONTROL = 8'h00;
	localparam logic [NUM_CH-1:0] RST_ENABLE = 8'h00;
	localparam logic [NUM_CH-1:0] RST_FLAGS = 8'h00;
	localparam logic [NUM_CH-1:0] RST_BUSY = 8'h00;
	localparam logic [NUM_CH-1:0] RST_USERS_READY = 8'h00;
	localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;

	// ****************************************************************
	// bus answer codes
	// ****************************************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : evr_pkg

// file: evr_chan.sv
/*
 * one event channel's state: busy tracking, users-ready capture,
 * event-detected and overrun flags.
 * assumes event, handled and ready inputs come from logic on core_clk.
 */
module evr_chan (
	input wire logic core_clk,
	input wire logic clr,
	input wire logic event_in,
	input wire logic async_path,
	input wire logic users_handled,
	input wire logic users_ready_in,
	input wire logic evd_clear,
	input wire logic ovr_clear,
	output logic busy_r,
	output logic users_ready_r,
	output logic event_detected_r,
	output logic channel_overrun_r
);

	// ****************************************************************
	// event qualification
	// ****************************************************************
	// asynchronous paths bypass all flag and busy tracking
	wire logic sync_event = event_in & ~async_path;
	wire logic overrun_hit = sync_event & (~users_ready_r | busy_r);
	wire logic busy_nxt = sync_event | (busy_r & ~users_handled);
	// set beats a clear in the same cycle
	wire logic evd_nxt = sync_event | (event_detected_r & ~evd_clear);
	wire logic ovr_nxt = overrun_hit | (channel_overrun_r & ~ovr_clear);

	// ****************************************************************
	// state
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (clr) begin
			busy_r <= 1'b0;
			users_ready_r <= 1'b0;
			event_detected_r <= 1'b0;
			channel_overrun_r <= 1'b0;
		end else begin
			busy_r <= busy_nxt;
			users_ready_r <= users_ready_in;
			event_detected_r <= evd_nxt;
			channel_overrun_r <= ovr_nxt;
		end
	end

endmodule // evr_chan

// file: evr_regs.sv
/*
 * control, channel status, interrupt enable and interrupt flag registers
 * of the eight-channel event router, as an AXI4-Lite slave.
 * assumes all inputs are on core_clk; the access protection controller
 * drives a write lock level; the event paths drive per-channel pulses.
 */
// Register access over AXI4-Lite was left to the implementer.
// Operation
// - 8-, 16- and 32-bit accesses, any byte or half, via byte strobes.
// - control and enable registers ignore writes while protection locks them.
// - writing 1 to soft reset bit resets every register; 0 does nothing.
// - busy bit high while a channel event is not handled by all users.
// - users-ready bit high only when every connected user is ready.
// - enable-clear bits 16-23 written 1 disable event-detected interrupt.
// - enable-clear bits 0-7 written 1 disable overrun interrupt.
// - enable-set bits 16-23 written 1 enable event-detected interrupt.
// - enable-set bits 0-7 written 1 enable overrun interrupt.
// - set and clear registers share one enable state, read alike, reset 0.
// - event-detected flag set cycle after a synchronous event; write 1 clears.
// - overrun flag set on event while users not ready or still busy.
module evr_regs (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [evr_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [evr_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [evr_pkg::STRB_W-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [evr_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [evr_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic write_lock,
	input wire logic [evr_pkg::NUM_CH-1:0] chan_event,
	input wire logic [evr_pkg::NUM_CH-1:0] chan_async,
	input wire logic [evr_pkg::NUM_CH-1:0] chan_handled,
	input wire logic [evr_pkg::NUM_CH-1:0] users_ready_in,
	output logic soft_reset_out,
	output logic irq
);

	localparam int N = evr_pkg::NUM_CH;

	// ****************************************************************
	// state declarations
	// ****************************************************************
	logic awready_r;
	logic wready_r;
	logic aw_held_r;
	logic w_held_r;
	logic [evr_pkg::ADDR_W-1:0] waddr_r;
	logic [evr_pkg::DATA_W-1:0] wdata_r;
	logic [evr_pkg::STRB_W-1:0] wstrb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [evr_pkg::DATA_W-1:0] rdata_r;
	logic [1:0] rresp_r;
	logic soft_reset_r;
	logic irq_r;
	logic [N-1:0] ien_evd_r;
	logic [N-1:0] ien_ovr_r;
	logic [N-1:0] ien_evd_nxt;
	logic [N-1:0] ien_ovr_nxt;
	logic [N-1:0] busy;
	logic [N-1:0] users_ready;
	logic [N-1:0] event_detected;
	logic [N-1:0] channel_overrun;

	// register bank clear: system reset or the software reset pulse
	wire logic clr = rst | soft_reset_r;

	// ****************************************************************
	// write channel handshakes
	// ****************************************************************
	wire logic aw_take = s_axi_awvalid & awready_r;
	wire logic w_take = s_axi_wvalid & wready_r;
	wire logic b_done = bvalid_r & s_axi_bready;
	// write executes once both halves are held and no answer is pending
	wire logic wr_fire = aw_held_r & w_held_r & ~bvalid_r;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			awready_r <= 1'b1;
			aw_held_r <= 1'b0;
			waddr_r <= '0;
		end else if (aw_take) begin
			awready_r <= 1'b0;
			aw_held_r <= 1'b1;
			waddr_r <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held_r <= 1'b0;
		end else if (b_done) begin
			awready_r <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wready_r <= 1'b1;
			w_held_r <= 1'b0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end else if (w_take) begin
			wready_r <= 1'b0;
			w_held_r <= 1'b1;
			wdata_r <= s_axi_wdata;
			wstrb_r <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held_r <= 1'b0;
		end else if (b_done) begin
			wready_r <= 1'b1;
		end
	end

	// ****************************************************************
	// write decode
	// ****************************************************************
	wire logic [5:0] waddr_word = waddr_r[evr_pkg::ADDR_W-1:2];
	wire logic hit_ctrl = (waddr_word == evr_pkg::OFS_UNIT_CONTROL[7:2]);
	wire logic hit_stat = (waddr_word == evr_pkg::OFS_CHANNEL_STATUS[7:2]);
	wire logic hit_iclr = (waddr_word == evr_pkg::OFS_IRQ_ENABLE_CLEAR[7:2]);
	wire logic hit_iset = (waddr_word == evr_pkg::OFS_IRQ_ENABLE_SET[7:2]);
	wire logic hit_flag = (waddr_word == evr_pkg::OFS_IRQ_FLAGS[7:2]);
	wire logic hit_prot = hit_ctrl | hit_iclr | hit_iset;
	wire logic w_mapped = hit_prot | hit_stat | hit_flag;
	// protected registers refuse writes while the lock is up
	wire logic w_blocked = hit_prot & write_lock;
	wire logic w_ok = wr_fire & w_mapped & ~w_blocked;

	// ****************************************************************
	// byte lanes and per-register write enables
	// ****************************************************************
	// each byte lane stands alone; lanes 1 and 3 hold no fields
	wire logic lane0_en = wstrb_r[evr_pkg::LOW_LANE];
	wire logic lane2_en = wstrb_r[evr_pkg::HIGH_LANE];
	wire logic [N-1:0] lo_byte = wdata_r[evr_pkg::OVERRUN_LSB +: N] & {N{lane0_en}};
	wire logic [N-1:0] hi_byte = wdata_r[evr_pkg::EVENT_DETECTED_LSB +: N] & {N{lane2_en}};
	wire logic ctrl_bit = wdata_r[evr_pkg::SOFT_RESET_BIT] & lane0_en;
	wire logic we_ctrl = w_ok & hit_ctrl;
	wire logic we_iclr = w_ok & hit_iclr;
	wire logic we_iset = w_ok & hit_iset;
	wire logic we_flag = w_ok & hit_flag;

	wire logic [N-1:0] iclr_evd = we_iclr ? hi_byte : '0;
	wire logic [N-1:0] iclr_ovr = we_iclr ? lo_byte : '0;
	wire logic [N-1:0] iset_evd = we_iset ? hi_byte : '0;
	wire logic [N-1:0] iset_ovr = we_iset ? lo_byte : '0;
	wire logic [N-1:0] fclr_evd = we_flag ? hi_byte : '0;
	wire logic [N-1:0] fclr_ovr = we_flag ? lo_byte : '0;
	wire logic soft_reset_nxt = we_ctrl & ctrl_bit;

	// ****************************************************************
	// write response
	// ****************************************************************
	wire logic [1:0] bresp_nxt = (w_mapped & ~w_blocked) ? evr_pkg::RESP_OKAY : evr_pkg::RESP_SLVERR;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			bvalid_r <= 1'b0;
			bresp_r <= evr_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			bresp_r <= bresp_nxt;
		end else if (b_done) begin
			bvalid_r <= 1'b0;
		end
	end

	// ****************************************************************
	// software reset pulse
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			soft_reset_r <= 1'b0;
		end else begin
			soft_reset_r <= soft_reset_nxt;
		end
	end

	// ****************************************************************
	// shared interrupt enable state
	// ****************************************************************
	// a simultaneous set and clear of one bit leaves it set
	assign ien_evd_nxt = iset_evd | (ien_evd_r & ~iclr_evd);
	assign ien_ovr_nxt = iset_ovr | (ien_ovr_r & ~iclr_ovr);

	always_ff @(posedge core_clk) begin
		if (clr) begin
			ien_evd_r <= evr_pkg::RST_ENABLE;
			ien_ovr_r <= evr_pkg::RST_ENABLE;
		end else begin
			ien_evd_r <= ien_evd_nxt;
			ien_ovr_r <= ien_ovr_nxt;
		end
	end

	// ****************************************************************
	// channels
	// ****************************************************************
	generate
		for (genvar ch = 0; ch < N; ch++) begin : g_chan
			evr_chan u_chan (
				.core_clk(core_clk),
				.clr(clr),
				.event_in(chan_event[ch]),
				.async_path(chan_async[ch]),
				.users_handled(chan_handled[ch]),
				.users_ready_in(users_ready_in[ch]),
				.evd_clear(fclr_evd[ch]),
				.ovr_clear(fclr_ovr[ch]),
				.busy_r(busy[ch]),
				.users_ready_r(users_ready[ch]),
				.event_detected_r(event_detected[ch]),
				.channel_overrun_r(channel_overrun[ch])
			);
		end
	endgenerate

	// ****************************************************************
	// interrupt
	// ****************************************************************
	wire logic [N-1:0] evd_pending = event_detected & ien_evd_r;
	wire logic [N-1:0] ovr_pending = channel_overrun & ien_ovr_r;
	wire logic irq_nxt = |(evd_pending | ovr_pending);

	always_ff @(posedge core_clk) begin
		if (clr) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	// ****************************************************************
	// read decode
	// ****************************************************************
	wire logic [5:0] raddr_word = s_axi_araddr[evr_pkg::ADDR_W-1:2];
	wire logic rhit_ctrl = (raddr_word == evr_pkg::OFS_UNIT_CONTROL[7:2]);
	wire logic rhit_stat = (raddr_word == evr_pkg::OFS_CHANNEL_STATUS[7:2]);
	wire logic rhit_ien = (raddr_word == evr_pkg::OFS_IRQ_ENABLE_CLEAR[7:2])
		| (raddr_word == evr_pkg::OFS_IRQ_ENABLE_SET[7:2]);
	wire logic rhit_flag = (raddr_word == evr_pkg::OFS_IRQ_FLAGS[7:2]);
	wire logic r_mapped = rhit_ctrl | rhit_stat | rhit_ien | rhit_flag;

	// ****************************************************************
	// read data words
	// ****************************************************************
	wire logic [evr_pkg::DATA_W-1:0] stat_word = {8'h00, busy, 8'h00, users_ready};
	wire logic [evr_pkg::DATA_W-1:0] ien_word = {8'h00, ien_evd_r, 8'h00, ien_ovr_r};
	wire logic [evr_pkg::DATA_W-1:0] flag_word = {8'h00, event_detected, 8'h00, channel_overrun};
	// control is write-only and reads zero
	wire logic [evr_pkg::DATA_W-1:0] rdata_nxt = rhit_stat ? stat_word
		: rhit_ien ? ien_word
		: rhit_flag ? flag_word
		: evr_pkg::RST_RDATA;
	wire logic [1:0] rresp_nxt = r_mapped ? evr_pkg::RESP_OKAY : evr_pkg::RESP_SLVERR;

	// ****************************************************************
	// read channel
	// ****************************************************************
	wire logic ar_take = s_axi_arvalid & arready_r;
	wire logic r_done = rvalid_r & s_axi_rready;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= evr_pkg::RST_RDATA;
			rresp_r <= evr_pkg::RESP_OKAY;
		end else if (ar_take) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end else if (r_done) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign soft_reset_out = soft_reset_r;
	assign irq = irq_r;

endmodule // evr_regs

// file: evr_regs_checker.sv
/* port checks of the event router register bank.
 * assumes a bind onto evr_regs; sees its ports only. */
module evr_regs_checker (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [evr_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [evr_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [evr_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic write_lock,
	input wire logic soft_reset_out,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	wire logic both_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire logic prot_addr = s_axi_awaddr[7:2] inside {6'h00, 6'h04, 6'h05};
	wire logic rd_take = s_axi_arvalid && s_axi_arready;
	wire logic rd_unmap = !(s_axi_araddr[7:2] inside {6'h00, 6'h03, 6'h04, 6'h05, 6'h06});
	property p_rst_quiet;
		$fell(rst) |-> !irq && !s_axi_bvalid && !s_axi_rvalid && !soft_reset_out;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("busy after reset");
	property p_b_answer;
		both_take |-> ##2 s_axi_bvalid;
	endproperty
	a_b_answer: assert property (p_b_answer) else $error("no write answer");
	property p_lock;
		both_take && write_lock && prot_addr |-> ##2 s_axi_bresp == evr_pkg::RESP_SLVERR;
	endproperty
	a_lock: assert property (p_lock) else $error("locked write taken");
	property p_unmap;
		rd_take && rd_unmap |=> s_axi_rresp == evr_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read answered");
	property p_ctrl_zero;
		rd_take && s_axi_araddr[7:2] == 6'h00 |=> s_axi_rvalid && s_axi_rdata == 32'h0;
	endproperty
	a_ctrl_zero: assert property (p_ctrl_zero) else $error("control read not zero");
	property p_lanes;
		s_axi_rvalid |-> s_axi_rdata[15:8] == 8'h00 && s_axi_rdata[31:24] == 8'h00;
	endproperty
	a_lanes: assert property (p_lanes) else $error("empty lane not zero");
	property p_srst;
		soft_reset_out |=> !irq && !soft_reset_out;
	endproperty
	a_srst: assert property (p_srst) else $error("soft reset pulse wrong");
	property p_ready_back;
		s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready;
	endproperty
	a_ready_back: assert property (p_ready_back) else $error("write port not free");
	c_srst: cover property (soft_reset_out);
	c_irq: cover property ($rose(irq));
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == evr_pkg::RESP_SLVERR);
endmodule // evr_regs_checker

// file: evr_users_model.sv
/* event paths and users on the far side of the channels.
 * assumes the bench commands events, completions and readiness. */
module evr_users_model (
	input wire logic core_clk,
	input wire logic [7:0] ev_cmd,
	input wire logic [7:0] done_cmd,
	input wire logic [7:0] ready_cfg,
	input wire logic [7:0] async_cfg,
	output logic [7:0] chan_event,
	output logic [7:0] chan_handled,
	output logic [7:0] users_ready_in,
	output logic [7:0] chan_async
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		chan_event = 8'h00;
		chan_handled = 8'h00;
		users_ready_in = 8'h00;
		chan_async = 8'h00;
	end
	// users launch and finish on the core_clk rising edge
	always @(posedge core_clk) begin
		chan_event <= ev_cmd;
		chan_handled <= done_cmd;
		users_ready_in <= ready_cfg;
		chan_async <= async_cfg;
	end
endmodule // evr_users_model

// file: evr_regs_tb_top.sv
/* self-checking bench of the event router register bank.
 * assumes evr_regs, its checker and the users model are compiled. */
module evr_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0, rst = 1'b1, write_lock = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic [7:0] ev_cmd = 8'h00, done_cmd = 8'h00, ready_cfg = 8'h00, async_cfg = 8'h00;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, soft_reset_out, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [7:0] chan_event, chan_handled, users_ready_in, chan_async;
	int num_errors = 0;
	int total_checks = 0;
	int srst_pulses = 0;
	always #5 core_clk = ~core_clk;
	// soft reset pulses seen: one per accepted request, one cycle each
	always @(posedge core_clk) begin
		if (soft_reset_out) begin
			srst_pulses <= srst_pulses + 1;
		end
	end
	evr_regs i_evr_regs (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .write_lock,
		.chan_event, .chan_async, .chan_handled, .users_ready_in, .soft_reset_out, .irq);
	evr_users_model i_evr_users_model (.core_clk, .ev_cmd, .done_cmd, .ready_cfg, .async_cfg,
		.chan_event, .chan_handled, .users_ready_in, .chan_async);
	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tmo(input int i);
		if (i >= 64) begin
			num_errors++;
			$display("[FAIL] %0t bus timeout", $time);
			print_verdict();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er = 2'h0);
		int i;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		tmo(i);
		chk({30'h0, s_axi_bresp}, {30'h0, er});
		s_axi_bready <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = 2'h0);
		int i;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge core_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		tmo(i);
		chk(s_axi_rdata, ed);
		chk({30'h0, s_axi_rresp}, {30'h0, er});
		s_axi_rready <= 1'b0;
		@(posedge core_clk);
	endtask
	// one event and completion pulse, with room for the readiness to settle
	task automatic ev(input logic [7:0] e, input logic [7:0] h);
		repeat (3) @(posedge core_clk);
		ev_cmd <= e;
		done_cmd <= h;
		@(posedge core_clk);
		ev_cmd <= 8'h00;
		done_cmd <= 8'h00;
		repeat (3) @(posedge core_clk);
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rd(8'h0c, 32'h0);
		rd(8'h10, 32'h0);
		rd(8'h00, 32'h0);
		wr(8'h14, 32'h00ff_00ff, 4'hf);
		rd(8'h10, 32'h00ff_00ff);
		wr(8'h10, 32'h0000_0003, 4'h1);
		wr(8'h10, 32'h0001_0000, 4'h4);
		wr(8'h10, 32'h0, 4'hf);
		rd(8'h14, 32'h00fe_00fc);
		wr(8'h14, 32'h0001_0003, 4'h3);
		rd(8'h10, 32'h00fe_00ff);
		write_lock <= 1'b1;
		wr(8'h14, 32'h0001_0000, 4'hf, 2'h2);
		wr(8'h00, 32'h1, 4'h1, 2'h2);
		chk(srst_pulses, 32'h0);
		wr(8'h0c, 32'h1, 4'hf);
		write_lock <= 1'b0;
		rd(8'h14, 32'h00fe_00ff);
		ready_cfg <= 8'ha5;
		ev(8'h01, 8'h00);
		rd(8'h0c, 32'h0001_00a5);
		rd(8'h18, 32'h0001_0000);
		chk({31'h0, irq}, 32'h0);
		ev(8'h01, 8'h00);
		rd(8'h18, 32'h0001_0001);
		chk({31'h0, irq}, 32'h1);
		ev(8'h00, 8'h01);
		rd(8'h0c, 32'h0000_00a5);
		wr(8'h18, 32'h0001_0001, 4'hf);
		rd(8'h18, 32'h0);
		chk({31'h0, irq}, 32'h0);
		ev(8'h02, 8'h00);
		rd(8'h18, 32'h0002_0002);
		chk({31'h0, irq}, 32'h1);
		async_cfg <= 8'h04;
		ev(8'h04, 8'h00);
		rd(8'h18, 32'h0002_0002);
		rd(8'h0c, 32'h0002_00a5);
		rd(8'h40, 32'h0, 2'h2);
		wr(8'h04, 32'h1, 4'hf, 2'h2);
		// generators quiet before the soft reset
		ready_cfg <= 8'h00;
		async_cfg <= 8'h00;
		wr(8'h00, 32'h0, 4'h1);
		chk(srst_pulses, 32'h0);
		rd(8'h14, 32'h00fe_00ff);
		wr(8'h00, 32'h1, 4'h1);
		chk(srst_pulses, 32'h1);
		rd(8'h10, 32'h0);
		rd(8'h18, 32'h0);
		rd(8'h0c, 32'h0);
		chk({31'h0, irq}, 32'h0);
		print_verdict();
	end
endmodule // evr_regs_tb_top
bind evr_regs evr_regs_checker i_evr_regs_checker (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .write_lock, .soft_reset_out, .irq);
